// file: src/rdc_ctrl.sv
// Receive-path direct command controller
//
// Behaviour
// - Clip and gain cut set only in active peer
// - Mask drops rx_on and stops framing
// - Effective mask is command OR timer mask
// - Unmask raises rx_on and enables framing
// - Unmask during mask timer resets timer immediately
// - Mask commands need receiver power enable
// - Mask commands chain, raise no interrupt
// - Amplitude drives transmitter, detector, absolute conversion
// - Amplitude code scaled, full input gives E6h
// - Amplitude measurement ends within 25 us
// - Amplitude, gain reset need enable and crystal
// - Amplitude blocks chaining, interrupt after finish
// - Squelch sequence ends within 500 us
// - Squelch needs tx and rx; runs when rx_on low
// - Squelch blocks chaining, raises no interrupt
// - Gain reset aborts squelch, loads manual gain
// - Gain reset chains, raises no interrupt
`timescale 1ns/1ps
module rdc_ctrl #(
  parameter int unsigned AMP_CYC = rdc_pkg::AMP_MAX_CYC,
  parameter int unsigned SQL_CYC = rdc_pkg::SQL_MAX_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire rdc_pkg::rdc_cmd_s cmd_i,
  input wire rdc_pkg::rdc_cond_s cond_i,
  input wire logic nfc_active_i,
  input wire logic mask_tmr_run_i,
  input wire logic [rdc_pkg::DATA_W-1:0] rx_cfg4_i,
  input wire logic adc_done_i,
  input wire logic [rdc_pkg::DATA_W-1:0] adc_data_i,
  input wire logic squelch_done_i,
  output rdc_pkg::rdc_resp_s resp_o,
  output logic rx_on_o,
  output logic framing_en_o,
  output logic rx_mask_o,
  output logic mask_tmr_rst_o,
  output logic stage_clip_en_o,
  output logic active_peer_gain_cut_o,
  output rdc_pkg::rdc_amp_s amp_o,
  output logic [rdc_pkg::DATA_W-1:0] adc_result_o,
  output rdc_pkg::rdc_sq_s sq_o,
  output rdc_pkg::rdc_gain_s gain_o
);
  import rdc_pkg::*;

  // Whole state of the block
  typedef struct packed {
    // Sequencer, command mask and stored result
    rdc_fsm_e st;
    logic mask_cmd;
    logic [DATA_W-1:0] adc_res;
    // One-cycle answers and pulses
    logic acc;
    logic rej;
    logic irq;
    logic adc_start;
    logic sq_start;
    logic mtmr_rst;
    logic reinit;
    logic load;
    // Held values
    logic [DATA_W-1:0] man_gain;
    logic clip;
    logic gcut;
  } rdc_ctrl_s;

  localparam rdc_ctrl_s RST_VAL = '{
    st: RDC_IDLE,
    mask_cmd: 1'b0,
    adc_res: ADC_RST,
    acc: 1'b0,
    rej: 1'b0,
    irq: 1'b0,
    adc_start: 1'b0,
    sq_start: 1'b0,
    mtmr_rst: 1'b0,
    reinit: 1'b0,
    load: 1'b0,
    man_gain: GAIN_RST,
    clip: 1'b0,
    gcut: 1'b0
  };

  rdc_ctrl_s q;
  rdc_ctrl_s d;

  logic amp_run;
  logic sql_run;
  logic amp_exp;
  logic sql_exp;
  logic eff_mask;
  logic en_ok;
  logic busy;
  logic [DATA_W-1:0] amp_code;
  logic mask_ok;
  logic amp_ok;
  logic sq_ok;
  logic gain_ok;
  logic sq_exec;
  logic amp_fin;
  logic sql_fin;

  // Sequence states decoded from the state register
  assign amp_run = (q.st == RDC_AMP);
  assign sql_run = (q.st == RDC_SQL);
  assign busy = (q.st != RDC_IDLE);

  // Oscillator enable and stable crystal gate the amplitude and gain reset commands
  assign en_ok = cond_i.osc_en & cond_i.xtal_ok;

  // Timer mask is gated in the reset cycle so that unmask acts at once
  assign eff_mask = q.mask_cmd | (mask_tmr_run_i & ~q.mtmr_rst);

  // Input can exceed full scale; clamp guards a noisy converter
  assign amp_code = (adc_data_i > AMP_FULL_CODE) ? AMP_FULL_CODE : adc_data_i;

  // Receiver power gates both mask commands
  assign mask_ok = cond_i.rx_en;

  // Measurement refused while a sequence runs: no chaining
  assign amp_ok = en_ok & ~busy;

  // Squelch wants both directions up and a free sequencer
  assign sq_ok = cond_i.tx_en & cond_i.rx_en & ~busy;

  // Gain reset goes through even mid-sequence, so it chains
  assign gain_ok = en_ok;

  // Squelch only starts while reception is masked
  assign sq_exec = eff_mask;

  // A sequence ends on the far side's done or on the local limit
  assign amp_fin = amp_run & (adc_done_i | amp_exp);
  assign sql_fin = sql_run & (squelch_done_i | sql_exp);

  // Limits one short of the bound: the registered expiry costs a cycle
  localparam int unsigned AMP_LIMIT = AMP_CYC - 1;
  localparam int unsigned SQL_LIMIT = SQL_CYC - 1;

  // Bound on the amplitude conversion
  rdc_timeout #(
    .LIMIT(AMP_LIMIT)
  ) u_amp_tmo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .run_i(amp_run),
    .expired_o(amp_exp)
  );

  // Bound on the squelch sequence
  rdc_timeout #(
    .LIMIT(SQL_LIMIT)
  ) u_sql_tmo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .run_i(sql_run),
    .expired_o(sql_exp)
  );

  // Next state: sequencer first, then the command decode may override it
  always_comb begin
    d = q;
    d.acc = 1'b0;
    d.rej = 1'b0;
    d.irq = 1'b0;
    d.adc_start = 1'b0;
    d.sq_start = 1'b0;
    d.mtmr_rst = 1'b0;
    d.reinit = 1'b0;
    d.load = 1'b0;

    // Receiver mode bits follow the peer-to-peer mode
    d.clip = nfc_active_i;
    d.gcut = nfc_active_i;

    // Running sequences
    case (q.st)
      RDC_IDLE: begin
        d.st = RDC_IDLE;
      end
      RDC_AMP: begin
        // Result stored in the same cycle as the completion interrupt
        if (amp_fin) begin
          d.adc_res = amp_code;
          d.irq = 1'b1;
          d.st = RDC_IDLE;
        end
      end
      RDC_SQL: begin
        // No interrupt at squelch completion
        if (sql_fin) begin
          d.st = RDC_IDLE;
        end
      end
      default: begin
        d.st = RDC_IDLE;
      end
    endcase

    // Command decode; a refusal touches nothing but the reject pulse
    if (cmd_i.valid) begin
      case (cmd_i.code)
        RDC_CMD_MASK: begin
          // Forces reception off until unmasked
          if (mask_ok) begin
            d.mask_cmd = 1'b1;
            d.acc = 1'b1;
          end else begin
            d.rej = 1'b1;
          end
        end
        RDC_CMD_UNMASK: begin
          // Clearing the command mask also cuts a running timer short
          if (mask_ok) begin
            d.mask_cmd = 1'b0;
            d.mtmr_rst = mask_tmr_run_i;
            d.acc = 1'b1;
          end else begin
            d.rej = 1'b1;
          end
        end
        RDC_CMD_AMP: begin
          // No chaining: refused while any sequence runs
          if (amp_ok) begin
            d.st = RDC_AMP;
            d.adc_start = 1'b1;
            d.acc = 1'b1;
          end else begin
            d.rej = 1'b1;
          end
        end
        RDC_CMD_SQUELCH: begin
          // Both directions must be up before anything is taken
          if (sq_ok) begin
            d.acc = 1'b1;
            // Accepted with rx_on high, but no sequence is started
            if (sq_exec) begin
              d.st = RDC_SQL;
              d.sq_start = 1'b1;
            end
          end else begin
            d.rej = 1'b1;
          end
        end
        RDC_CMD_RGAIN: begin
          // Reinitialise gain, squelch and signal strength together
          if (gain_ok) begin
            d.reinit = 1'b1;
            d.load = 1'b1;
            d.man_gain = rx_cfg4_i;
            d.acc = 1'b1;
            // Abort a squelch in progress, amplitude work goes on
            if (sql_run) begin
              d.st = RDC_IDLE;
            end
          end else begin
            d.rej = 1'b1;
          end
        end
        default: begin
          // Unknown codes are answered but change nothing
          d.rej = 1'b1;
        end
      endcase
    end
  end

  // Single state register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

  // Host-side status; busy is a handshake term
  assign resp_o.accept = q.acc;
  assign resp_o.reject = q.rej;
  assign resp_o.irq = q.irq;
  assign resp_o.busy = busy;

  // Receiver enable and framing follow the combined mask
  assign rx_on_o = ~eff_mask;
  assign framing_en_o = ~eff_mask;

  // Mask level and timer reset toward the receive timer
  assign rx_mask_o = eff_mask;
  assign mask_tmr_rst_o = q.mtmr_rst;

  // Peer-to-peer receiver configuration
  assign stage_clip_en_o = q.clip;
  assign active_peer_gain_cut_o = q.gcut;

  // Amplitude path held for the whole conversion
  assign amp_o.tx_force = amp_run;
  assign amp_o.det_en = amp_run;
  assign amp_o.adc_sel_amp = amp_run;
  assign amp_o.adc_abs = amp_run;

  // Converter kick-off, in the same cycle as the accept pulse
  assign amp_o.adc_start = q.adc_start;

  // Result holds until the next measurement ends
  assign adc_result_o = q.adc_res;

  // Squelch sequencer handshake
  assign sq_o.start = q.sq_start;
  assign sq_o.run = sql_run;

  // Reinitialisation pulses; abort and clear go with the reinit
  assign gain_o.reinit = q.reinit;
  assign gain_o.sq_abort = q.reinit;
  assign gain_o.sq_clear = q.reinit;
  assign gain_o.load = q.load;

  // Manual gain stays loaded until the next accepted gain reset
  assign gain_o.man_gain = q.man_gain;

endmodule : rdc_ctrl

// file: src/rdc_pkg.sv
// Shared types and constants for the receive direct command controller
package rdc_pkg;

  // Clock and time figures
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned AMP_MAX_NS = 25000;
  localparam int unsigned SQL_MAX_NS = 500000;
  // Longest times round down to whole cycles
  localparam int unsigned AMP_MAX_CYC = (AMP_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned SQL_MAX_CYC = (SQL_MAX_NS / 4) * 1000 / (CLK_PERIOD_PS / 4);
  localparam int unsigned TMR_W = 17;

  // Amplitude scaling: one code step is 13.02 mVpp at the inputs
  localparam int unsigned AMP_LSB_UVPP = 13020;
  localparam logic [7:0] AMP_FULL_CODE = 8'hE6;

  // Widths and reset values
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] ADC_RST = 8'h00;
  localparam logic [7:0] GAIN_RST = 8'h00;

  // Direct commands handled here
  typedef enum logic [2:0] {
    RDC_CMD_NONE = 3'h0,
    RDC_CMD_MASK = 3'h1,
    RDC_CMD_UNMASK = 3'h2,
    RDC_CMD_AMP = 3'h3,
    RDC_CMD_SQUELCH = 3'h4,
    RDC_CMD_RGAIN = 3'h5
  } rdc_cmd_e;

  // Sequencer states, Gray along idle-amp-squelch
  typedef enum logic [1:0] {
    RDC_IDLE = 2'h0,
    RDC_AMP = 2'h1,
    RDC_SQL = 2'h3
  } rdc_fsm_e;

  // Command strobe with its code
  typedef struct packed {
    logic valid;
    rdc_cmd_e code;
  } rdc_cmd_s;

  // Acceptance conditions
  typedef struct packed {
    logic osc_en;
    logic xtal_ok;
    logic rx_en;
    logic tx_en;
  } rdc_cond_s;

  // Command status back to the host port
  typedef struct packed {
    logic accept;
    logic reject;
    logic irq;
    logic busy;
  } rdc_resp_s;

  // Amplitude measurement controls
  typedef struct packed {
    logic tx_force;
    logic det_en;
    logic adc_sel_amp;
    logic adc_abs;
    logic adc_start;
  } rdc_amp_s;

  // Squelch sequencer controls
  typedef struct packed {
    logic start;
    logic run;
  } rdc_sq_s;

  // Gain, squelch and signal-strength reinitialisation
  typedef struct packed {
    logic reinit;
    logic sq_abort;
    logic sq_clear;
    logic load;
    logic [7:0] man_gain;
  } rdc_gain_s;

endpackage : rdc_pkg

// file: src/rdc_timeout.sv
// Cycle limit counter for bounded command sequences
`timescale 1ns/1ps
module rdc_timeout #(
  parameter int unsigned LIMIT = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic expired_o
);
  import rdc_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic exp;
  } rdc_tmo_s;

  localparam logic [TMR_W-1:0] LAST = TMR_W'(LIMIT - 1);

  rdc_tmo_s q;
  rdc_tmo_s d;

  // Counts only while the sequence runs, clears when idle
  always_comb begin
    d = q;
    d.exp = 1'b0;
    if (!run_i) begin
      d.cnt = '0;
    end else if (q.cnt >= LAST) begin
      d.exp = 1'b1;
    end else begin
      d.cnt = q.cnt + TMR_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired_o = q.exp;

endmodule : rdc_timeout

// file: verification/rdc_ana_model.sv
// Far-side model: converter and squelch sequencer answering after a set wait
`timescale 1ns/1ps
module rdc_ana_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic adc_start_i,
  input wire logic sq_start_i,
  input wire logic [7:0] wait_i,
  input wire logic [7:0] code_i,
  output logic adc_done_o,
  output logic [7:0] adc_data_o,
  output logic squelch_done_o
);
  logic [7:0] cnt_q;
  logic is_adc_q;
  // Zero wait never answers, so the design's own limits get exercised
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
      is_adc_q <= 1'b0;
    end else if (adc_start_i || sq_start_i) begin
      cnt_q <= wait_i;
      is_adc_q <= adc_start_i;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // Done lasts one cycle; code is inverted outside it so stale reads show
  assign adc_done_o = is_adc_q && cnt_q == 8'h01;
  assign squelch_done_o = !is_adc_q && cnt_q == 8'h01;
  assign adc_data_o = adc_done_o ? code_i : ~code_i;
endmodule : rdc_ana_model

// file: verification/rdc_ctrl_checker.sv
// Concurrent checks on the receive direct command controller ports
`timescale 1ns/1ps
module rdc_ctrl_checker
  import rdc_pkg::*;
#(
  parameter int unsigned AMP_CYC = 20,
  parameter int unsigned SQL_CYC = 40
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire rdc_pkg::rdc_cmd_s cmd_i,
  input wire rdc_pkg::rdc_cond_s cond_i,
  input wire logic nfc_active_i,
  input wire logic mask_tmr_run_i,
  input wire logic [rdc_pkg::DATA_W-1:0] rx_cfg4_i,
  input wire rdc_pkg::rdc_resp_s resp_o,
  input wire logic rx_on_o,
  input wire logic framing_en_o,
  input wire logic rx_mask_o,
  input wire logic mask_tmr_rst_o,
  input wire logic stage_clip_en_o,
  input wire logic active_peer_gain_cut_o,
  input wire rdc_pkg::rdc_amp_s amp_o,
  input wire logic [rdc_pkg::DATA_W-1:0] adc_result_o,
  input wire rdc_pkg::rdc_sq_s sq_o,
  input wire rdc_pkg::rdc_gain_s gain_o
);
  localparam int AMP_LIM = AMP_CYC;
  localparam int SQL_LIM = SQL_CYC;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_mode;
    stage_clip_en_o == $past(nfc_active_i) && active_peer_gain_cut_o == stage_clip_en_o;
  endproperty
  a_mode: assert property (p_mode) else $error("mode bits wrong");
  property p_mask;
    cmd_i.valid && cmd_i.code == RDC_CMD_MASK && cond_i.rx_en |=> !rx_on_o && !framing_en_o;
  endproperty
  a_mask: assert property (p_mask) else $error("mask ignored");
  property p_tmr;
    mask_tmr_run_i && !mask_tmr_rst_o |-> rx_mask_o && !rx_on_o;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer mask lost");
  property p_unmask;
    cmd_i.valid && cmd_i.code == RDC_CMD_UNMASK && cond_i.rx_en |=> rx_on_o && framing_en_o;
  endproperty
  a_unmask: assert property (p_unmask) else $error("unmask ignored");
  property p_pwr;
    cmd_i.valid && cmd_i.code inside {RDC_CMD_MASK, RDC_CMD_UNMASK} && !cond_i.rx_en
      |=> resp_o.reject && !resp_o.accept;
  endproperty
  a_pwr: assert property (p_pwr) else $error("mask taken unpowered");
  property p_amp;
    amp_o.adc_start |-> amp_o.tx_force && amp_o.det_en && amp_o.adc_sel_amp && amp_o.adc_abs;
  endproperty
  a_amp: assert property (p_amp) else $error("amplitude path off");
  property p_amp_end;
    $rose(amp_o.det_en) |-> ##[1:AMP_LIM] !amp_o.det_en;
  endproperty
  a_amp_end: assert property (p_amp_end) else $error("amplitude too long");
  property p_irq;
    resp_o.irq |-> $past(amp_o.det_en) && !amp_o.det_en && !resp_o.busy;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not at end");
  property p_sq_end;
    $rose(sq_o.run) |-> ##[1:SQL_LIM] !sq_o.run;
  endproperty
  a_sq_end: assert property (p_sq_end) else $error("squelch too long");
  property p_sq_run;
    sq_o.start |-> $past(rx_mask_o) && sq_o.run;
  endproperty
  a_sq_run: assert property (p_sq_run) else $error("squelch with rx on");
  property p_gain;
    gain_o.load |-> !sq_o.run && gain_o.man_gain == $past(rx_cfg4_i);
  endproperty
  a_gain: assert property (p_gain) else $error("gain reset wrong");
  property p_code;
    adc_result_o <= AMP_FULL_CODE;
  endproperty
  a_code: assert property (p_code) else $error("code above full");
endmodule : rdc_ctrl_checker

bind rdc_ctrl rdc_ctrl_checker #(.AMP_CYC(AMP_CYC), .SQL_CYC(SQL_CYC)) u_chk (
  .ref_clk_i, .rst_i, .cmd_i, .cond_i, .nfc_active_i, .mask_tmr_run_i, .rx_cfg4_i,
  .resp_o, .rx_on_o, .framing_en_o, .rx_mask_o, .mask_tmr_rst_o, .stage_clip_en_o,
  .active_peer_gain_cut_o, .amp_o, .adc_result_o, .sq_o, .gain_o
);

// file: verification/tb_rdc_ctrl.sv
// Self-checking bench for the receive direct command controller
`timescale 1ns/1ps
module tb_rdc_ctrl;
  import rdc_pkg::*;
  localparam int unsigned AMP_N = 20;
  localparam int unsigned SQL_N = 40;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  rdc_cmd_s cmd = '0;
  rdc_cond_s cond = '0;
  logic nfc = 1'b0;
  logic tmr_run = 1'b0;
  logic [7:0] cfg4 = 8'h00;
  logic [7:0] mdl_wait = 8'h00;
  logic [7:0] mdl_code = 8'h00;
  logic adc_done, sq_done, rx_on, fr_en, rx_mask, tmr_rst, clip, gcut;
  logic [7:0] adc_data, adc_res;
  rdc_resp_s resp;
  rdc_amp_s amp;
  rdc_sq_s sq;
  rdc_gain_s gain;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;

  always #2 ref_clk_i = ~ref_clk_i;

  rdc_ctrl #(.AMP_CYC(AMP_N), .SQL_CYC(SQL_N)) uut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_i(cmd), .cond_i(cond), .nfc_active_i(nfc),
    .mask_tmr_run_i(tmr_run), .rx_cfg4_i(cfg4), .adc_done_i(adc_done), .adc_data_i(adc_data),
    .squelch_done_i(sq_done), .resp_o(resp), .rx_on_o(rx_on), .framing_en_o(fr_en),
    .rx_mask_o(rx_mask), .mask_tmr_rst_o(tmr_rst), .stage_clip_en_o(clip),
    .active_peer_gain_cut_o(gcut), .amp_o(amp), .adc_result_o(adc_res), .sq_o(sq),
    .gain_o(gain));

  rdc_ana_model u_ana (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .adc_start_i(amp.adc_start), .sq_start_i(sq.start),
    .wait_i(mdl_wait), .code_i(mdl_code), .adc_done_o(adc_done), .adc_data_o(adc_data),
    .squelch_done_o(sq_done));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // One-cycle strobe; returns where the answer stands
  task automatic send(input rdc_cmd_e c);
    @(negedge ref_clk_i);
    cmd <= '{valid: 1'b1, code: c};
    @(negedge ref_clk_i);
    cmd.valid <= 1'b0;
  endtask : send

  task automatic wait_idle(input int lim);
    for (int n = 0; n < lim && resp.busy !== 1'b0; n++) @(negedge ref_clk_i);
  endtask : wait_idle

  task automatic t_mask();
    nfc <= 1'b1;
    cond.rx_en <= 1'b1;
    send(RDC_CMD_MASK);
    check("clip", {7'h00, clip}, 8'h01);
    check("gcut", {7'h00, gcut}, 8'h01);
    check("rx_on", {7'h00, rx_on}, 8'h00);
    check("irq", {7'h00, resp.irq}, 8'h00);
    nfc <= 1'b0;
    send(RDC_CMD_UNMASK);
    check("framing", {7'h00, fr_en}, 8'h01);
    check("clip0", {7'h00, clip}, 8'h00);
    cond.rx_en <= 1'b0;
    send(RDC_CMD_MASK);
    check("reject", {7'h00, resp.reject}, 8'h01);
    check("rx_on", {7'h00, rx_on}, 8'h01);
    cond.rx_en <= 1'b1;
    tmr_run <= 1'b1;
    @(negedge ref_clk_i);
    check("tmr mask", {7'h00, rx_mask}, 8'h01);
    send(RDC_CMD_UNMASK);
    check("tmr rst", {7'h00, tmr_rst}, 8'h01);
    check("rx_on", {7'h00, rx_on}, 8'h01);
    tmr_run <= 1'b0;
  endtask : t_mask

  task automatic t_amp();
    cond.xtal_ok <= 1'b1;
    send(RDC_CMD_AMP);
    check("amp refused", {7'h00, amp.adc_start}, 8'h00);
    cond.osc_en <= 1'b1;
    mdl_wait <= 8'h05;
    mdl_code <= AMP_FULL_CODE;
    send(RDC_CMD_AMP);
    check("amp start", {7'h00, amp.adc_start & amp.det_en & amp.adc_abs}, 8'h01);
    send(RDC_CMD_AMP);
    check("amp chain", {7'h00, resp.reject}, 8'h01);
    wait_idle(AMP_N + 4);
    check("amp irq", {7'h00, resp.irq}, 8'h01);
    check("amp code", adc_res, 8'hE6);
    mdl_wait <= 8'h00;
    mdl_code <= 8'hFF;
    send(RDC_CMD_AMP);
    wait_idle(AMP_N + 3);
    check("amp limit", {7'h00, resp.irq}, 8'h01);
    check("amp stale", adc_res, 8'h00);
  endtask : t_amp

  task automatic t_sql();
    cond.tx_en <= 1'b1;
    send(RDC_CMD_MASK);
    mdl_wait <= 8'h1E;
    send(RDC_CMD_SQUELCH);
    check("sq start", {7'h00, sq.start}, 8'h01);
    send(RDC_CMD_SQUELCH);
    check("sq chain", {7'h00, resp.reject}, 8'h01);
    cfg4 <= 8'h5A;
    send(RDC_CMD_RGAIN);
    check("sq abort", {7'h00, sq.run | resp.irq}, 8'h00);
    check("man gain", gain.man_gain, 8'h5A);
    check("pulses", {4'h0, gain.reinit, gain.sq_abort, gain.sq_clear, gain.load}, 8'h0F);
    mdl_wait <= 8'h00;
    send(RDC_CMD_SQUELCH);
    wait_idle(SQL_N + 3);
    check("sq limit", {7'h00, sq.run}, 8'h00);
    send(RDC_CMD_UNMASK);
    send(RDC_CMD_SQUELCH);
    check("sq rx on", {6'h00, resp.accept, sq.start}, 8'h02);
    send(RDC_CMD_NONE);
    check("bad code", {6'h00, resp.accept, resp.reject}, 8'h01);
    cond.osc_en <= 1'b0;
    cfg4 <= 8'hA5;
    send(RDC_CMD_RGAIN);
    check("gain refused", {6'h00, resp.accept, resp.reject}, 8'h01);
    check("gain kept", gain.man_gain, 8'h5A);
  endtask : t_sql

  // Hang guard; whole run needs under two hundred cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i <= 1'b0;
    t_mask();
    t_amp();
    t_sql();
    report_and_stop();
  end
endmodule : tb_rdc_ctrl
